// ===== hdl/adc_host_end.sv
// Host controller: starts conversions, reads results and queues them.
`timescale 1ns/1ps
module adc_host_end #(
  parameter int CHAIN_DEVICES = 1,
  parameter int FIFO_DEPTH = adc_link_pkg::FIFO_DEPTH_DEFAULT
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  adc_link_if.host link,
  input wire logic i_start,
  input wire adc_link_pkg::link_mode_t i_mode,
  output logic o_busy,
  output logic [adc_link_pkg::RESULT_BITS-1:0] o_word,
  output logic o_word_valid,
  input wire logic i_word_ready
);
  localparam int NB = adc_link_pkg::RESULT_BITS;
  localparam int TOTAL_BITS = NB * CHAIN_DEVICES;

  if (CHAIN_DEVICES < 1 || CHAIN_DEVICES > 15) begin : g_check
    $error("adc_host_end: CHAIN_DEVICES must be 1 to 15");
  end

  adc_link_pkg::host_state_t state, next_state;
  adc_link_pkg::link_mode_t mode, next_mode;
  logic [15:0] cnt, next_cnt;
  logic [15:0] gap, next_gap;
  logic [7:0] bits, next_bits;
  logic [NB-1:0] shreg, next_shreg;
  logic start_pin, next_start_pin;
  logic sclk, next_sclk;
  logic din, next_din;
  logic push, next_push;
  logic dout_s1;
  logic dout_s2;
  logic fifo_ready;

  assign link.conversion_start_select = start_pin;
  assign link.sclk = sclk;
  assign link.din = din;
  assign o_busy = state != adc_link_pkg::ST_IDLE;

  // Queue of results; a full queue stalls the serial clock.
  sample_fifo #(.WIDTH(NB), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_in_valid(push),
    .o_in_ready(fifo_ready),
    .i_in_data(shreg),
    .o_out_valid(o_word_valid),
    .i_out_ready(i_word_ready),
    .o_out_data(o_word)
  );

  // Sequencer: mode setup, conversion wait, select, shift, release.
  always_comb begin
    next_state = state;
    next_mode = mode;
    next_cnt = (cnt != 16'h0000) ? cnt - 16'h0001 : cnt;
    next_gap = (gap != 16'h0000) ? gap - 16'h0001 : gap;
    next_bits = bits;
    next_shreg = shreg;
    next_start_pin = start_pin;
    next_sclk = sclk;
    next_din = din;
    next_push = push & ~fifo_ready;
    unique case (state)
      adc_link_pkg::ST_IDLE: begin
        if (i_start && gap == 16'h0000 && !push) begin
          next_mode = i_mode;
          next_din = i_mode != adc_link_pkg::MODE_DAISY;
          next_cnt = 16'(adc_link_pkg::SU_DI_CYC - 1);
          next_state = adc_link_pkg::ST_SETUP;
        end
      end
      adc_link_pkg::ST_SETUP: begin
        // Serial clock rests low across the rising edge.
        if (cnt == 16'h0000) begin
          next_start_pin = 1'b1;
          next_cnt = 16'(adc_link_pkg::CONV_MAX_CYC - 1);
          next_gap = 16'(adc_link_pkg::CYCLE_MIN_CYC - 1);
          next_state = adc_link_pkg::ST_CONVERT;
        end
      end
      adc_link_pkg::ST_CONVERT: begin
        // Read only after the longest conversion has passed.
        if (cnt == 16'h0000) begin
          if (mode == adc_link_pkg::MODE_4WIRE) begin
            next_din = 1'b0;
          end else begin
            next_start_pin = 1'b0;
            next_din = 1'b0;
          end
          next_bits = '0;
          next_cnt = 16'(adc_link_pkg::SCLK_HALF_CYC - 1);
          next_state = adc_link_pkg::ST_SELECT;
        end
      end
      adc_link_pkg::ST_SELECT: begin
        if (cnt == 16'h0000) begin
          next_sclk = 1'b1;
          next_cnt = 16'(adc_link_pkg::SCLK_HALF_CYC - 1);
          next_state = adc_link_pkg::ST_SHIFT;
        end
      end
      adc_link_pkg::ST_SHIFT: begin
        if (push && !fifo_ready) begin
          next_cnt = cnt; // Hold the clock while the queue is full.
        end else if (cnt == 16'h0000 && sclk) begin
          // Capture just before the falling edge.
          next_shreg = {shreg[NB-2:0], dout_s2};
          next_sclk = 1'b0;
          next_bits = bits + 8'h01;
          next_push = bits[3:0] == 4'hf;
          next_cnt = 16'(adc_link_pkg::SCLK_HALF_CYC - 1);
        end else if (cnt == 16'h0000) begin
          if (bits == 8'(TOTAL_BITS)) begin
            next_din = mode == adc_link_pkg::MODE_4WIRE ? 1'b1 : din;
            next_cnt = 16'(adc_link_pkg::QUIET_CYC - 1);
            next_state = adc_link_pkg::ST_RELEASE;
          end else begin
            next_sclk = 1'b1;
            next_cnt = 16'(adc_link_pkg::SCLK_HALF_CYC - 1);
          end
        end
      end
      adc_link_pkg::ST_RELEASE: begin
        if (cnt == 16'h0000) begin
          // The start pin rests low so that the next conversion sees a rising edge.
          next_start_pin = 1'b0;
          next_din = 1'b1;
          next_state = adc_link_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = adc_link_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer registers and two-stage capture of the serial output.
  always_ff @(posedge i_mclk) begin
    dout_s1 <= link.dout_line;
    dout_s2 <= dout_s1;
    if (!i_rstn) begin
      state <= adc_link_pkg::ST_IDLE;
      mode <= adc_link_pkg::MODE_3WIRE;
      cnt <= '0;
      gap <= '0;
      bits <= '0;
      shreg <= adc_link_pkg::RESULT_RESET;
      start_pin <= 1'b0;
      sclk <= 1'b0;
      din <= 1'b1;
      push <= 1'b0;
    end else begin
      state <= next_state;
      mode <= next_mode;
      cnt <= next_cnt;
      gap <= next_gap;
      bits <= next_bits;
      shreg <= next_shreg;
      start_pin <= next_start_pin;
      sclk <= next_sclk;
      din <= next_din;
      push <= next_push;
    end
  end
endmodule

// ===== hdl/adc_link_pkg.sv
// Shared constants, modes and states for the converter serial readout link.
package adc_link_pkg;

  // Result word and clock of the surrounding logic.
  localparam int RESULT_BITS = 16;
  localparam int CLK_PERIOD_PS = 4000;

  // Link timing figures in their own units.
  localparam int T_CONV_MIN_NS = 500;
  localparam int T_CONV_MAX_NS = 8800;
  localparam int T_CONV_TYP_NS = 4000;
  localparam int T_CYCLE_MIN_NS = 10000;
  localparam int T_WH_START_NS = 10;
  localparam int T_QUIET_NS = 20;
  localparam int T_SCLK_MIN_PS = 62500;
  localparam int T_SU_DI_START_PS = 7500;

  // Cycle counts derived from the figures; least times round up.
  localparam int CONV_MIN_CYC = (T_CONV_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CONV_MAX_CYC = (T_CONV_MAX_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CONV_TYP_CYC = (T_CONV_TYP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CYCLE_MIN_CYC = (T_CYCLE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WH_START_CYC = (T_WH_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int QUIET_CYC = (T_QUIET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SU_DI_CYC = (T_SU_DI_START_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SCLK_HALF_CYC = (T_SCLK_MIN_PS / 2 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Values after reset and the default queue depth.
  localparam logic [RESULT_BITS-1:0] RESULT_RESET = 16'h0000;
  localparam int FIFO_DEPTH_DEFAULT = 8;

  // Interface modes chosen by the host.
  typedef enum logic [2:0] {
    MODE_3WIRE = 3'b001,
    MODE_4WIRE = 3'b010,
    MODE_DAISY = 3'b100
  } link_mode_t;

  // Host sequencer states.
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_SETUP = 6'b00_0010,
    ST_CONVERT = 6'b00_0100,
    ST_SELECT = 6'b00_1000,
    ST_SHIFT = 6'b01_0000,
    ST_RELEASE = 6'b10_0000
  } host_state_t;

endpackage

// ===== hdl/adc_link_if.sv
// Pin bundle joining the host end and the converter end.
`timescale 1ns/1ps
interface adc_link_if;
  logic conversion_start_select;
  logic sclk;
  logic din;
  logic dout;
  logic dout_oe;
  wire dout_line;

  // A released serial output reads low, as if held by a pull-down.
  assign dout_line = dout_oe & dout;

  modport host (output conversion_start_select, output sclk, output din, input dout_line);
  modport device (input conversion_start_select, input sclk, input din, output dout,
                  output dout_oe);
endinterface

// ===== hdl/sample_fifo.sv
// Word FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  // Depth must be a power of two so the pointers wrap naturally.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_check
    $error("sample_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic do_write;
  logic do_read;

  // Full when the pointers differ only in the wrap bit.
  assign o_in_ready = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
  assign o_out_valid = wr_ptr != rd_ptr;
  assign o_out_data = mem[rd_ptr[AW-1:0]];
  assign do_write = i_in_valid & o_in_ready;
  assign do_read = o_out_valid & i_out_ready;

  // Pointer advance.
  always_comb begin
    next_wr_ptr = do_write ? wr_ptr + (AW+1)'(1) : wr_ptr;
    next_rd_ptr = do_read ? rd_ptr + (AW+1)'(1) : rd_ptr;
  end

  // Pointer registers and storage.
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
    if (do_write) begin
      mem[wr_ptr[AW-1:0]] <= i_in_data;
    end
  end
endmodule

// ===== hdl/adc_device_end.sv
// Converter end: conversion timing, mode capture and serial readout.
`timescale 1ns/1ps

module adc_device_end #(
  parameter int CONV_CYC = adc_link_pkg::CONV_TYP_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  adc_link_if.device link,
  input wire logic signed [adc_link_pkg::RESULT_BITS-1:0] i_sample,
  output logic o_busy,
  output logic o_power_down,
  output logic o_daisy,
  output logic [adc_link_pkg::RESULT_BITS-1:0] o_result
);
  localparam int NB = adc_link_pkg::RESULT_BITS;

  // Conversion length must fall inside the documented window.
  if (CONV_CYC < adc_link_pkg::CONV_MIN_CYC || CONV_CYC > adc_link_pkg::CONV_MAX_CYC) begin : g_check
    $error("adc_device_end: CONV_CYC outside the conversion time window");
  end

  // ---------------------------------------------------------------
  // Internal clock domain: conversion and mode capture.
  // ---------------------------------------------------------------

  logic start_s1;
  logic start_s2;
  logic start_s3;
  logic din_s1;
  logic din_s2;
  logic busy, next_busy;
  logic [15:0] conv_cnt, next_conv_cnt;
  logic daisy, next_daisy;
  logic [NB-1:0] held, next_held;
  logic [NB-1:0] result, next_result;
  logic start_rise;

  // A rising start edge while idle begins a conversion; edges during one are ignored.
  assign start_rise = start_s2 & ~start_s3 & ~busy;

  // Conversion sequencing on the internal clock only.
  always_comb begin
    next_busy = busy;
    next_conv_cnt = conv_cnt;
    next_daisy = daisy;
    next_held = held;
    next_result = result;
    if (start_rise) begin
      next_busy = 1'b1;
      next_conv_cnt = 16'(CONV_CYC - 1);
      next_daisy = ~din_s2;
      next_held = i_sample;
    end else if (busy) begin
      if (conv_cnt == 16'h0000) begin
        next_busy = 1'b0;
        next_result = held;
      end else begin
        next_conv_cnt = conv_cnt - 16'h0001;
      end
    end
  end

  // Pin synchronisers and conversion registers.
  always_ff @(posedge i_mclk) begin
    start_s1 <= link.conversion_start_select;
    start_s2 <= start_s1;
    start_s3 <= start_s2;
    din_s1 <= link.din;
    din_s2 <= din_s1;
    if (!i_rstn) begin
      busy <= 1'b0;
      conv_cnt <= '0;
      daisy <= 1'b0;
      held <= adc_link_pkg::RESULT_RESET;
      result <= adc_link_pkg::RESULT_RESET;
    end else begin
      busy <= next_busy;
      conv_cnt <= next_conv_cnt;
      daisy <= next_daisy;
      held <= next_held;
      result <= next_result;
    end
  end

  // Status toward the user side of the converter.
  assign o_busy = busy;
  assign o_power_down = ~busy;
  assign o_daisy = daisy;
  assign o_result = result;

  // ---------------------------------------------------------------
  // Link clock domain: serial shift out and daisy pass-through.
  // ---------------------------------------------------------------
  // The result word, the mode and the busy flag cross as quasi-static
  // levels: they only change inside a conversion, and the host reads
  // only after the longest conversion, so they are settled long before
  // the first serial clock edge of a frame.

  logic cs_n;
  logic [4:0] bit_idx, next_bit_idx;
  logic [NB-1:0] chain, next_chain;
  logic [3:0] bit_sel;
  logic past_word;

  // Chip select: start pin alone in daisy, start pin and data-in in 3-wire and 4-wire.
  // In 3-wire the host drops both pins together, so either pin selects.
  assign cs_n = daisy ? link.conversion_start_select
                      : (link.conversion_start_select & link.din);

  // Bit pointer and chain shift on the falling serial clock edge.
  always_comb begin
    next_bit_idx = bit_idx[4] ? bit_idx : bit_idx + 5'h01;
    next_chain = daisy ? {chain[NB-2:0], link.din} : chain;
  end

  // Deselect clears the frame, so every frame starts at the MSB.
  always_ff @(negedge link.sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_idx <= '0;
      chain <= adc_link_pkg::RESULT_RESET;
    end else begin
      bit_idx <= next_bit_idx;
      chain <= next_chain;
    end
  end

  // Bit selection, MSB first; the MSB shows as soon as select falls.
  assign bit_sel = 4'(NB - 1) - bit_idx[3:0];
  assign past_word = bit_idx[4];

  // Daisy passes upstream bits after the own word; select modes release.
  assign link.dout = (daisy && past_word) ? chain[NB-1] : result[bit_sel];

  // Drive only when selected, not converting, and before the last fall
  // in select modes; daisy keeps driving until the start pin rises.
  assign link.dout_oe = ~cs_n & ~busy & (daisy | ~past_word);
endmodule

// ===== dv/adc_link_assertions.sv
// Checker for the serial readout link between the host end and the converter end.
`timescale 1ns/1ps
module adc_link_assertions (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic conversion_start_select,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic dout_line
);
  logic cs_n;
  logic start_d;
  logic next_start_d;
  logic sclk_d;
  logic next_sclk_d;
  logic daisy;
  logic next_daisy;
  logic [4:0] falls;
  logic [4:0] next_falls;

  // Select-style chip select is low while either pin is low.
  assign cs_n = conversion_start_select & din;

  // Track the strapped mode and count serial clock falls within a frame.
  always_comb begin
    next_start_d = conversion_start_select;
    next_sclk_d = sclk;
    next_daisy = (conversion_start_select && !start_d) ? !din : daisy;
    next_falls = falls;
    if (daisy ? conversion_start_select : cs_n) begin
      next_falls = 5'h0;
    end else if (sclk_d && !sclk && falls != 5'h1f) begin
      next_falls = falls + 5'h1;
    end
  end

  // Register the tracking state.
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      start_d <= 1'b0;
      sclk_d <= 1'b0;
      daisy <= 1'b0;
      falls <= 5'h0;
    end else begin
      start_d <= next_start_d;
      sclk_d <= next_sclk_d;
      daisy <= next_daisy;
      falls <= next_falls;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  a_oe_off_start: assert property (
    conversion_start_select && din |-> !dout_oe) else $error("output driven while deselected");
  a_oe_off_count: assert property (
    !daisy && falls >= 5'h10 |-> !dout_oe) else $error("output driven after sixteen bits");
  a_oe_hold_frame: assert property (
    !daisy && !cs_n && $past(dout_oe) && next_falls < 5'h10 |-> dout_oe)
    else $error("output dropped within a frame");
  a_msb_on_select: assert property (
    !daisy && $fell(cs_n) |-> ##[0:2] dout_oe) else $error("output not driven after select");
  a_dout_steady_high: assert property (
    sclk && $past(sclk) && dout_oe && $past(dout_oe) |-> $stable(dout))
    else $error("output changed without a clock fall");
  a_daisy_pass_on: assert property (
    daisy && falls == 5'h10 && !conversion_start_select |-> dout_oe && !dout)
    else $error("chained input not passed to output");
  a_strap_stable: assert property (
    $rose(conversion_start_select) |-> $stable(din)) else $error("strap moved at start edge");
  a_sclk_quiet_start: assert property (
    $rose(conversion_start_select) |-> !sclk && $stable(sclk))
    else $error("serial clock moved at start edge");
  a_no_read_convert: assert property (
    $rose(conversion_start_select) |=> !sclk [*8]) else $error("read during conversion");

  c_select_frame: cover property (!daisy && falls == 5'h10);
  c_daisy_frame: cover property (daisy && falls == 5'h10);
  c_select_fall: cover property ($fell(cs_n));
endmodule

// ===== dv/tb_top.sv
// Self-checking bench joining the host end and the converter end over one link.
`timescale 1ns/1ps
`define CHECK(name, exp, got) begin tests_run++; if ((got) !== (exp)) begin fails++; \
  $display("Error %s expected %h seen %h", name, exp, got); end end
module tb_top;
  logic i_mclk = 1'b0;
  logic dev_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_start = 1'b0;
  adc_link_pkg::link_mode_t i_mode = adc_link_pkg::MODE_3WIRE;
  logic i_word_ready = 1'b0;
  logic signed [15:0] i_sample = 16'sh0000;
  logic host_busy;
  logic word_valid;
  logic dev_busy;
  logic dev_pd;
  logic dev_daisy;
  logic [15:0] word;
  logic [15:0] dev_result;
  logic [15:0] mon_bits = 16'h0000;
  int fails = 0;
  int tests_run = 0;

  adc_link_if link ();

  adc_host_end #(.CHAIN_DEVICES(1), .FIFO_DEPTH(8)) adc_host_end_i (.i_mclk(i_mclk),
    .i_rstn(i_rstn), .link(link.host), .i_start(i_start), .i_mode(i_mode), .o_busy(host_busy),
    .o_word(word), .o_word_valid(word_valid), .i_word_ready(i_word_ready));

  // The converter runs from the slower unrelated clock with a shortened conversion.
  adc_device_end #(.CONV_CYC(500)) adc_device_end_i (.i_mclk(dev_clk), .i_rstn(i_rstn),
    .link(link.device), .i_sample(i_sample), .o_busy(dev_busy), .o_power_down(dev_pd),
    .o_daisy(dev_daisy), .o_result(dev_result));

  adc_link_assertions adc_link_assertions_i (.i_mclk(i_mclk), .i_rstn(i_rstn),
    .conversion_start_select(link.conversion_start_select), .sclk(link.sclk), .din(link.din),
    .dout(link.dout), .dout_oe(link.dout_oe), .dout_line(link.dout_line));

  // Both clocks run free with unrelated phases.
  initial begin
    forever #2 i_mclk = ~i_mclk;
  end
  initial begin
    #3.3;
    forever #7.5 dev_clk = ~dev_clk;
  end

  // The wire is sampled on serial clock rises, where the current bit is settled.
  always @(posedge link.sclk) begin
    mon_bits <= {mon_bits[14:0], link.dout_line};
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic tally_and_finish();
    $display("tests run %0d, fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Requests one conversion and holds the request until the host takes it.
  task automatic run_frame(input adc_link_pkg::link_mode_t m, input logic [15:0] s);
    int k;
    @(posedge i_mclk);
    i_sample <= s;
    i_mode <= m;
    i_start <= 1'b1;
    k = 0;
    do begin
      @(posedge i_mclk);
      #1;
      k++;
    end while (host_busy !== 1'b1 && k < 4000);
    `CHECK("start taken", 1'b1, host_busy)
    @(posedge i_mclk);
    i_start <= 1'b0;
  endtask

  // Waits under a bound until the host sequencer is idle again.
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      @(posedge i_mclk);
      #1;
      k++;
    end while (host_busy !== 1'b0 && k < 4000);
    `CHECK("host idle", 1'b0, host_busy)
  endtask

  // Compares the queue head and pops it with a one-edge ready pulse.
  task automatic pop_word(input logic [15:0] exp);
    int k;
    k = 0;
    while (word_valid !== 1'b1 && k < 4000) begin
      @(posedge i_mclk);
      #1;
      k++;
    end
    `CHECK("queued word", exp, word)
    @(posedge i_mclk);
    i_word_ready <= 1'b1;
    @(posedge i_mclk);
    i_word_ready <= 1'b0;
    #1;
  endtask

  // Every mode twice, with the sign boundaries among the codes.
  task automatic test_modes();
    adc_link_pkg::link_mode_t modes[3];
    logic [15:0] vals[3];
    logic [15:0] v;
    modes = '{adc_link_pkg::MODE_3WIRE, adc_link_pkg::MODE_4WIRE, adc_link_pkg::MODE_DAISY};
    vals = '{16'h8000, 16'h7fff, 16'h5a3c};
    for (int i = 0; i < 3; i++) begin
      for (int j = 0; j < 2; j++) begin
        v = vals[(i + j) % 3];
        run_frame(modes[i], v);
        repeat (100) @(posedge i_mclk);
        #1;
        `CHECK("device busy", 1'b1, dev_busy)
        `CHECK("powered up", 1'b0, dev_pd)
        wait_idle();
        `CHECK("device idle", 1'b0, dev_busy)
        `CHECK("daisy strap", modes[i] == adc_link_pkg::MODE_DAISY, dev_daisy)
        `CHECK("device result", v, dev_result)
        `CHECK("power down", 1'b1, dev_pd)
        `CHECK("wire bits", v, mon_bits)
        if (modes[i] == adc_link_pkg::MODE_3WIRE) begin
          `CHECK("output released", 1'b0, link.dout_oe)
        end
        pop_word(v);
      end
    end
    $display("test modes done");
  endtask

  // Fills the queue, checks the host stalls, then drains in order.
  task automatic test_fifo_full();
    for (int n = 0; n < 9; n++) begin
      run_frame(adc_link_pkg::MODE_3WIRE, 16'(16'h1000 + n));
      if (n < 8) begin
        wait_idle();
      end
    end
    repeat (3000) @(posedge i_mclk);
    #1;
    `CHECK("host stalled", 1'b1, host_busy)
    for (int n = 0; n < 9; n++) begin
      pop_word(16'(16'h1000 + n));
    end
    wait_idle();
    `CHECK("queue empty", 1'b0, word_valid)
    $display("test fifo full done");
  endtask

  // Cuts a hang short well beyond the expected run length.
  initial begin
    #250000;
    fails++;
    $display("Error watchdog expected finish seen hang");
    tally_and_finish();
  end

  // Main sequence.
  initial begin
    repeat (12) @(posedge i_mclk);
    i_rstn <= 1'b1;
    test_modes();
    test_fifo_full();
    tally_and_finish();
  end
endmodule
